// File: spx_pkg.sv
package spx_pkg;
  // stack transfer opcodes
  typedef enum logic [7:0] {
    OP_POP_REG = 8'h50,
    OP_POP_INDIRECT = 8'h51,
    OP_PUSH_REG = 8'h70,
    OP_PUSH_INDIRECT = 8'h71,
    OP_USER_STACK_POP_DECREMENTING = 8'h92,
    OP_USER_STACK_POP_INCREMENTING = 8'h93,
    OP_USER_STACK_PUSH_DECREMENTING = 8'h82
  } spx_opcode_t;
  // execution sequence
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RPTR = 3'b001,
    ST_RDAT = 3'b010,
    ST_WDAT = 3'b011,
    ST_WPTR = 3'b100,
    ST_WAIT = 3'b101
  } spx_state_t;
  // instruction as loaded by software
  typedef struct packed {
    logic [7:0] op2;
    logic [7:0] op1;
    logic [7:0] opcode;
  } spx_instr_t;
endpackage

// File: spx_regfile_mem.sv
`timescale 1ns/1ps
module spx_regfile_mem #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 256
) (
  // clock
  input wire logic clk,
  // single port
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic we,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [DEPTH];

  // read before write, read data registered
  always_ff @(posedge clk) begin
    rdata <= mem[addr];
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule

// File: spx_regs.svh
`ifndef SPX_REGS_SVH
`define SPX_REGS_SVH
// register indices, byte address is four times the index
`define SPX_IDX_INSTR 10'h000
`define SPX_IDX_CTRL 10'h001
`define SPX_IDX_FLAGS 10'h002
`define SPX_IDX_MADDR 10'h003
`define SPX_IDX_MDATA 10'h004
`define SPX_IDX_STACK_HI 10'h0d8
`define SPX_IDX_STACK_LO 10'h0d9
// control write bits and status read bits
`define SPX_CTRL_GO 0
`define SPX_CTRL_CLR 1
`define SPX_ST_BUSY 0
`define SPX_ST_DONE 1
`define SPX_ST_ILL 2
// reset values
`define SPX_SP_RESET 16'h0000
`define SPX_FLAGS_RESET 6'h00
`define SPX_INSTR_RESET 24'h000000
// timing and bus answers
`define SPX_EXEC_CYCLES 8
`define SPX_RESP_OKAY 2'b00
`define SPX_RESP_SLVERR 2'b10
`endif

// File: spx_stack_exec.sv
`timescale 1ns/1ps
`include "spx_regs.svh"
// Operation
// RULE1: pop reads byte at system stack pointer into destination, then increments pointer
// RULE2: no pop or push instruction changes any condition flag
// RULE3: decrementing user pop copies byte at user pointer, then decrements it
// RULE4: opcode 92 is decrementing user pop, source byte before destination, 8 cycles
// RULE5: opcode 93 user pop copies byte at user pointer, then increments it
// RULE6: push decrements system stack pointer first, then stores source byte there
// RULE7: push on pointer zero wraps to all ones before storing
// RULE8: opcode 82 decrements user pointer, then writes source to addressed register
// RULE9: system stack pointer is high byte at d8 and low byte at d9
// RULE10: pointer steps carry and borrow across both bytes as one counter
// RULE11: user pointer is one register byte, steps wrap modulo 256
module spx_stack_exec #(
  parameter int ADDR_W = 12,
  parameter int CYCLES = `SPX_EXEC_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int CW = $clog2(CYCLES);

  spx_pkg::spx_state_t state, next_state;
  spx_pkg::spx_instr_t instr;
  logic [15:0] sp, sp_start;
  logic [5:0] flags;
  logic [7:0] maddr, ptr, mem_addr, mem_wdata, mem_rdata, rd_addr, wr_addr;
  logic [CW-1:0] cnt;
  logic done, illegal, mem_we;
  logic aw_held, w_held, rd_pend, rd_s2, rd_bad;
  logic [9:0] aw_idx, ar_idx;
  logic [31:0] w_data, status, rd_val;
  logic [3:0] w_strb;

  function automatic logic is_mapped(input logic [9:0] idx);
    return idx == `SPX_IDX_INSTR || idx == `SPX_IDX_CTRL || idx == `SPX_IDX_FLAGS ||
      idx == `SPX_IDX_MADDR || idx == `SPX_IDX_MDATA || idx == `SPX_IDX_STACK_HI ||
      idx == `SPX_IDX_STACK_LO;
  endfunction

  // 16-bit step, carry and borrow ripple across both bytes
  function automatic logic [15:0] step16(input logic [15:0] v, input logic up);
    return up ? 16'(v + 16'h0001) : 16'(v - 16'h0001); // RULE10 RULE7
  endfunction

  // 8-bit step, wraps inside the register file
  function automatic logic [7:0] step8(input logic [7:0] v, input logic up);
    return up ? 8'(v + 8'h01) : 8'(v - 8'h01); // RULE11
  endfunction

  // opcode classes
  wire [7:0] opc = instr.opcode;
  wire op_pop = opc == spx_pkg::OP_POP_REG || opc == spx_pkg::OP_POP_INDIRECT;
  wire op_push = opc == spx_pkg::OP_PUSH_REG || opc == spx_pkg::OP_PUSH_INDIRECT;
  wire is_upop_dec = opc == spx_pkg::OP_USER_STACK_POP_DECREMENTING; // RULE4
  wire is_upop_inc = opc == spx_pkg::OP_USER_STACK_POP_INCREMENTING;
  wire is_upush_dec = opc == spx_pkg::OP_USER_STACK_PUSH_DECREMENTING;
  wire op_user = is_upop_dec || is_upop_inc || is_upush_dec;
  wire legal = op_pop || op_push || op_user;
  wire busy = state != spx_pkg::ST_IDLE;
  wire fin = state == spx_pkg::ST_WAIT && cnt == CW'(CYCLES - 1);

  // pointer arithmetic, system pop and user pop 93 count up, other opcodes count down
  wire [15:0] sp_next = step16(sp, op_pop);
  wire [7:0] usp_next = step8(ptr, is_upop_inc);

  // source and destination selection per opcode
  assign rd_addr = op_pop ? sp[7:0] : // RULE1
    opc == spx_pkg::OP_PUSH_REG ? instr.op1 :
    is_upush_dec ? instr.op2 : mem_rdata; // RULE3 RULE5
  assign wr_addr = opc == spx_pkg::OP_POP_REG ? instr.op1 :
    opc == spx_pkg::OP_POP_INDIRECT ? ptr :
    op_push ? sp_next[7:0] : // RULE6 RULE9
    is_upush_dec ? usp_next : instr.op2; // RULE8

  // bus write decode, all writes refused while an instruction runs
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire rd_inflight = rd_pend || rd_s2;
  wire go_req = aw_idx == `SPX_IDX_CTRL && w_strb[0] && w_data[`SPX_CTRL_GO];
  wire wr_ok = is_mapped(aw_idx) && !busy && !(go_req && rd_inflight);
  wire wr_go = wr_fire && wr_ok;
  wire start = wr_go && go_req && legal;
  wire bad_op = wr_go && go_req && !legal;
  wire clr = wr_go && aw_idx == `SPX_IDX_CTRL && w_strb[0] && w_data[`SPX_CTRL_CLR];
  wire sw_lo = wr_go && w_strb[0];

  // memory port: executor owns it while busy
  assign mem_addr = !busy ? maddr :
    state == spx_pkg::ST_RDAT ? rd_addr :
    state == spx_pkg::ST_WDAT ? wr_addr : instr.op1;
  assign mem_we = busy ? (state == spx_pkg::ST_WDAT ||
    (state == spx_pkg::ST_WPTR && op_user)) : sw_lo && aw_idx == `SPX_IDX_MDATA;
  assign mem_wdata = !busy ? w_data[7:0] :
    state == spx_pkg::ST_WPTR ? usp_next : mem_rdata;

  spx_regfile_mem #(.DATA_W(8), .DEPTH(256)) u_mem (
    .clk(aclk),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // read side selection
  assign status = (32'(busy) << `SPX_ST_BUSY) | (32'(done) << `SPX_ST_DONE) |
    (32'(illegal) << `SPX_ST_ILL);
  assign rd_val = ar_idx == `SPX_IDX_INSTR ? {8'h00, instr} :
    ar_idx == `SPX_IDX_CTRL ? status :
    ar_idx == `SPX_IDX_FLAGS ? {26'h0, flags} :
    ar_idx == `SPX_IDX_MADDR ? {24'h0, maddr} :
    ar_idx == `SPX_IDX_MDATA ? {24'h0, mem_rdata} :
    ar_idx == `SPX_IDX_STACK_HI ? {24'h0, sp[15:8]} : {24'h0, sp[7:0]}; // RULE9

  // handshakes
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !rd_inflight && !s_axi_rvalid;

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 10'h000;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[11:2];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `SPX_RESP_OKAY : `SPX_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one cycle to address memory, one for its data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend <= 1'b0;
      rd_s2 <= 1'b0;
      rd_bad <= 1'b0;
      ar_idx <= 10'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SPX_RESP_OKAY;
    end else begin
      rd_pend <= s_axi_arvalid && s_axi_arready;
      rd_s2 <= rd_pend;
      if (s_axi_arvalid && s_axi_arready) begin
        ar_idx <= s_axi_araddr[11:2];
      end
      if (rd_pend) begin
        rd_bad <= !is_mapped(ar_idx) || (ar_idx == `SPX_IDX_MDATA && busy);
      end
      if (rd_s2) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_bad ? 32'h0 : rd_val;
        s_axi_rresp <= rd_bad ? `SPX_RESP_SLVERR : `SPX_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // software registers; flags are only ever written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr <= `SPX_INSTR_RESET;
      flags <= `SPX_FLAGS_RESET;
      maddr <= 8'h00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_go && aw_idx == `SPX_IDX_INSTR && w_strb[i]) begin
          instr[8*i +: 8] <= w_data[8*i +: 8];
        end
      end
      if (sw_lo && aw_idx == `SPX_IDX_FLAGS) begin
        flags <= w_data[5:0]; // RULE2
      end
      if (sw_lo && aw_idx == `SPX_IDX_MADDR) begin
        maddr <= w_data[7:0];
      end
    end
  end

  // system stack pointer: pop steps after its read, push before its store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp <= `SPX_SP_RESET;
    end else if (state == spx_pkg::ST_WDAT && !op_user) begin
      sp <= sp_next; // RULE1 RULE6
    end else begin
      if (sw_lo && aw_idx == `SPX_IDX_STACK_HI) begin
        sp[15:8] <= w_data[7:0]; // RULE9
      end
      if (sw_lo && aw_idx == `SPX_IDX_STACK_LO) begin
        sp[7:0] <= w_data[7:0];
      end
    end
  end

  // sequence: pointer read, data read, data write, pointer write, pad
  always_comb begin
    unique case (state)
      spx_pkg::ST_IDLE: next_state = start ? spx_pkg::ST_RPTR : spx_pkg::ST_IDLE;
      spx_pkg::ST_RPTR: next_state = spx_pkg::ST_RDAT;
      spx_pkg::ST_RDAT: next_state = spx_pkg::ST_WDAT;
      spx_pkg::ST_WDAT: next_state = spx_pkg::ST_WPTR;
      spx_pkg::ST_WPTR: next_state = spx_pkg::ST_WAIT;
      spx_pkg::ST_WAIT: next_state = fin ? spx_pkg::ST_IDLE : spx_pkg::ST_WAIT;
      default: next_state = spx_pkg::ST_IDLE;
    endcase
  end

  // executor state; done set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= spx_pkg::ST_IDLE;
      cnt <= '0;
      ptr <= 8'h00;
      done <= 1'b0;
      illegal <= 1'b0;
      sp_start <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= start ? '0 : CW'(cnt + 1'b1); // RULE4
      if (state == spx_pkg::ST_RDAT) begin
        ptr <= mem_rdata;
      end
      if (start) begin
        sp_start <= sp;
      end
      done <= fin || (done && !clr);
      illegal <= bad_op || (illegal && !clr);
    end
  end

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pop_order;
    state == spx_pkg::ST_RDAT && op_pop |-> mem_addr == sp[7:0]
      ##1 (mem_we && $stable(sp)) ##1 sp == 16'($past(sp) + 16'h0001);
  endproperty
  a_pop_order: assert property (p_pop_order) else $error("pop order wrong"); // RULE1

  property p_pop_carry;
    fin && op_pop |-> sp == 16'(sp_start + 16'h0001);
  endproperty
  a_pop_carry: assert property (p_pop_carry) else $error("pop sp wrong"); // RULE10

  property p_flags;
    busy |=> $stable(flags);
  endproperty
  a_flags: assert property (p_flags) else $error("flags changed"); // RULE2

  property p_length;
    start |=> busy [*8] ##1 !busy;
  endproperty
  a_length: assert property (p_length) else $error("cycle count wrong"); // RULE4

  property p_user_stack_pop_decrementing;
    state == spx_pkg::ST_WPTR && is_upop_dec |-> mem_we && mem_addr == instr.op1 &&
      mem_wdata == 8'(ptr - 8'h01);
  endproperty
  a_user_stack_pop_decrementing: assert property (p_user_stack_pop_decrementing) else $error("user pop dec wrong"); // RULE3

  property p_user_stack_pop_incrementing;
    state == spx_pkg::ST_WPTR && is_upop_inc |-> mem_we && mem_wdata == 8'(ptr + 8'h01);
  endproperty
  a_user_stack_pop_incrementing: assert property (p_user_stack_pop_incrementing) else $error("user pop inc wrong"); // RULE5

  property p_push;
    fin && op_push |-> sp == 16'(sp_start - 16'h0001);
  endproperty
  a_push: assert property (p_push) else $error("push sp wrong"); // RULE6

  property p_push_wrap;
    state == spx_pkg::ST_WDAT && op_push && sp == 16'h0000 |-> mem_addr == 8'hff
      ##1 sp == 16'hffff;
  endproperty
  a_push_wrap: assert property (p_push_wrap) else $error("push wrap wrong"); // RULE7

  property p_user_stack_push_decrementing;
    state == spx_pkg::ST_WDAT && is_upush_dec |-> mem_we && mem_addr == 8'(ptr - 8'h01);
  endproperty
  a_user_stack_push_decrementing: assert property (p_user_stack_push_decrementing) else $error("user push wrong"); // RULE8
endmodule

// File: test_stack_push_pop_execution.sv
`timescale 1ns/1ps
`include "spx_regs.svh"
module test_stack_push_pop_execution;
  // register byte addresses
  localparam logic [11:0] A_INSTR = {`SPX_IDX_INSTR, 2'b00};
  localparam logic [11:0] A_CTRL = {`SPX_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_FLAGS = {`SPX_IDX_FLAGS, 2'b00};
  localparam logic [11:0] A_MADDR = {`SPX_IDX_MADDR, 2'b00};
  localparam logic [11:0] A_MDATA = {`SPX_IDX_MDATA, 2'b00};
  localparam logic [11:0] A_STACK_HI = {`SPX_IDX_STACK_HI, 2'b00};
  localparam logic [11:0] A_STACK_LO = {`SPX_IDX_STACK_LO, 2'b00};
  localparam logic [1:0] OK = `SPX_RESP_OKAY;
  localparam logic [1:0] ERR = `SPX_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fails = 0;
  int samples_checked = 0;

  // 200 mhz core clock
  always #2.5 aclk = ~aclk;

  spx_stack_exec dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic tally_and_finish();
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bus write: sampling right after the edge sees pre-edge values
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    check("write response", {30'h0, bresp}, {30'h0, er});
  endtask

  // bus read, one at a time
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (rvalid !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(nm, d, e);
    check("read response", {30'h0, r}, {30'h0, OK});
  endtask

  // register file reached through the address/data window
  task automatic mset(input logic [7:0] a, input logic [7:0] d);
    wr(A_MADDR, {24'h0, a}, OK);
    wr(A_MDATA, {24'h0, d}, OK);
  endtask

  task automatic mchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    wr(A_MADDR, {24'h0, a}, OK);
    rchk(nm, A_MDATA, {24'h0, e});
  endtask

  task automatic setsp(input logic [7:0] h, input logic [7:0] l);
    wr(A_STACK_HI, {24'h0, h}, OK);
    wr(A_STACK_LO, {24'h0, l}, OK);
  endtask

  // start one instruction; a write while busy must be refused
  task automatic run(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    wr(A_INSTR, {8'h00, o2, o1, op}, OK);
    wr(A_CTRL, 32'h1, OK);
    wr(A_FLAGS, 32'h0, ERR);
    do begin
      rd(A_CTRL, d, r);
      n++;
    end while (d[`SPX_ST_DONE] !== 1'b1 && n < 20);
    check("done", {31'h0, d[`SPX_ST_DONE]}, 32'h1);
    // a run that never finishes ends the test here
    if (d[`SPX_ST_DONE] !== 1'b1) begin
      tally_and_finish();
    end
    check("illegal", {31'h0, d[`SPX_ST_ILL]}, 32'h0);
    wr(A_CTRL, 32'h2, OK);
  endtask

  // reset values, flags set, unmapped place refused
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rchk("stack hi reset", A_STACK_HI, 32'h0);
    rchk("stack lo reset", A_STACK_LO, 32'h0);
    rd(12'h0f0, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, ERR});
    check("unmapped data", d, 32'h0);
    wr(12'h0f0, 32'h5a, ERR);
    wr(A_FLAGS, 32'h3f, OK);
  endtask

  // push from pointer zero wraps to all ones, then indirect push
  task automatic t_push();
    mset(8'h40, 8'h4f);
    mset(8'h4f, 8'haa);
    run(spx_pkg::OP_PUSH_REG, 8'h40, 8'h00);
    rchk("push stack hi", A_STACK_HI, 32'hff);
    rchk("push stack lo", A_STACK_LO, 32'hff);
    mchk("push store", 8'hff, 8'h4f);
    run(spx_pkg::OP_PUSH_INDIRECT, 8'h40, 8'h00);
    rchk("push ind stack lo", A_STACK_LO, 32'hfe);
    mchk("push ind store", 8'hfe, 8'haa);
  endtask

  // pops, including a carry from low into high pointer byte
  task automatic t_pop();
    setsp(8'h00, 8'hfb);
    mset(8'hfb, 8'h55);
    mset(8'h00, 8'h01);
    run(spx_pkg::OP_POP_INDIRECT, 8'h00, 8'h00);
    mchk("pop ind dst", 8'h01, 8'h55);
    rchk("pop ind stack lo", A_STACK_LO, 32'hfc);
    wr(A_STACK_LO, 32'hfb, OK);
    run(spx_pkg::OP_POP_REG, 8'h00, 8'h00);
    mchk("pop dst", 8'h00, 8'h55);
    setsp(8'h00, 8'hff);
    mset(8'hff, 8'h3c);
    run(spx_pkg::OP_POP_REG, 8'h10, 8'h00);
    mchk("pop carry dst", 8'h10, 8'h3c);
    rchk("pop carry stack hi", A_STACK_HI, 32'h01);
    rchk("pop carry stack lo", A_STACK_LO, 32'h00);
  endtask

  // user stacks, with modulo 256 wrap of the pointer byte
  task automatic t_user();
    mset(8'h00, 8'h42);
    mset(8'h42, 8'h6f);
    run(spx_pkg::OP_USER_STACK_POP_DECREMENTING, 8'h00, 8'h02);
    mchk("popd dst", 8'h02, 8'h6f);
    mchk("popd ptr", 8'h00, 8'h41);
    mset(8'h00, 8'hff);
    mset(8'hff, 8'h70);
    run(spx_pkg::OP_USER_STACK_POP_INCREMENTING, 8'h00, 8'h03);
    mchk("popi dst", 8'h03, 8'h70);
    mchk("popi ptr wrap", 8'h00, 8'h00);
    mset(8'h00, 8'h03);
    mset(8'h01, 8'h05);
    run(spx_pkg::OP_USER_STACK_PUSH_DECREMENTING, 8'h00, 8'h01);
    mchk("pushd ptr", 8'h00, 8'h02);
    mchk("pushd store", 8'h02, 8'h05);
    mset(8'h20, 8'h00);
    run(spx_pkg::OP_USER_STACK_PUSH_DECREMENTING, 8'h20, 8'h01);
    mchk("pushd wrap ptr", 8'h20, 8'hff);
    mchk("pushd wrap store", 8'hff, 8'h05);
  endtask

  // unsupported opcode is flagged sticky, nothing runs, clear drops it
  task automatic t_illegal();
    logic [31:0] d;
    logic [1:0] r;
    wr(A_INSTR, 32'h000083, OK);
    wr(A_CTRL, 32'h1, OK);
    rd(A_CTRL, d, r);
    check("illegal status", {29'h0, d[2:0]}, 32'h4);
    wr(A_CTRL, 32'h2, OK);
    rchk("illegal cleared", A_CTRL, 32'h0);
  endtask

  // main sequence, reset held five cycles
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_push();
    t_pop();
    t_user();
    t_illegal();
    rchk("flags kept", A_FLAGS, 32'h3f);
    tally_and_finish();
  end
endmodule
